// ==== design/tccs_pkg.sv ====
// package: constants, types and register map of the timer clock and clear select block
package tccs_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int NUM_CH = 6;
    localparam int CNT_W = 16;
    localparam int DIV_W = 12;
    localparam int ADDR_W = 5;

    // ------------------------------------------------------------
    // register map (word addresses on the plain port)
    // ------------------------------------------------------------
    localparam logic [4:0] ADDR_CTRL0 = 5'h00;
    localparam logic [4:0] ADDR_CNT0 = 5'h08;
    localparam logic [4:0] ADDR_SYNC = 5'h10;
    localparam logic [4:0] ADDR_PHASE = 5'h11;

    // ------------------------------------------------------------
    // reset values and counter maximum
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [5:0] SYNC_RST = 6'h00;
    localparam logic [5:0] PHASE_RST = 6'h00;
    localparam logic [11:0] DIV_RST = 12'h000;
    localparam logic [15:0] CNT_MAX = 16'hffff;

    // ------------------------------------------------------------
    // prescaler tap positions: square wave of period 2^(tap+1)
    // ------------------------------------------------------------
    localparam int TAP_D4 = 1;
    localparam int TAP_D16 = 3;
    localparam int TAP_D64 = 5;
    localparam int TAP_D256 = 7;
    localparam int TAP_D1024 = 9;
    localparam int TAP_D4096 = 11;

    // ------------------------------------------------------------
    // field encodings
    // ------------------------------------------------------------
    localparam logic [1:0] CLR_NONE = 2'h0;
    localparam logic [1:0] CLR_GRA = 2'h1;
    localparam logic [1:0] CLR_GRB = 2'h2;
    localparam logic [1:0] CLR_SYNC = 2'h3;

    typedef enum logic [3:0] {
        SRC_D1 = 4'h0,
        SRC_D4 = 4'h1,
        SRC_D16 = 4'h2,
        SRC_D64 = 4'h3,
        SRC_D256 = 4'h4,
        SRC_D1024 = 4'h5,
        SRC_D4096 = 4'h6,
        SRC_PIN_A = 4'h7,
        SRC_PIN_B = 4'h8,
        SRC_PIN_C = 4'h9,
        SRC_PIN_D = 4'ha,
        SRC_OVF2 = 4'hb,
        SRC_OVF5 = 4'hc
    } tccs_src_t;

    // per channel control: bit7 clear hi, 6:5 clear sel, 4:3 edge, 2:0 prescale
    typedef struct packed {
        logic clear_source_sel_hi2;
        logic clear_source_sel_hi;
        logic clear_source_sel_lo;
        logic edge_select_hi;
        logic edge_select_lo;
        logic prescale_sel_bit2;
        logic prescale_sel_bit1;
        logic prescale_sel_bit0;
    } tccs_ctrl_t;

    typedef struct packed {
        logic wr_stb;
        logic rd_stb;
        logic [4:0] addr;
        logic [15:0] wdata;
    } tccs_bus_req_t;

    typedef struct packed {
        logic [5:0] match_a;
        logic [5:0] match_b;
        logic [5:0] phase_step;
        logic [5:0] phase_down;
    } tccs_event_t;

endpackage : tccs_pkg

// ==== design/tccs_top.sv ====
// timer clock source and counter clear selection for six 16-bit channels
//
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
module tccs_top (
    input wire logic ref_clk, // 200 MHz system clock
    input wire logic sys_rst, // synchronous reset, active high
    input wire tccs_pkg::tccs_bus_req_t bus_req, // register port request
    output logic [15:0] rd_data, // read data, cycle after the read strobe
    input wire logic ext_clock_pin_a, // external count clock A
    input wire logic ext_clock_pin_b, // external count clock B
    input wire logic ext_clock_pin_c, // external count clock C
    input wire logic ext_clock_pin_d, // external count clock D
    input wire tccs_pkg::tccs_event_t events, // compare/capture and phase pulses
    output logic [5:0][15:0] channel_count_value, // live count of each channel
    output logic [5:0] wrap_pulse, // overflow or underflow, one cycle
    output logic [5:0] clear_pulse, // counter was cleared, one cycle
    output logic [5:0] count_enable // count enable issued, one cycle
);

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    // channels without registers C and D have no top clear bit
    function automatic logic has_clr_hi(input int ch);
        has_clr_hi = (ch == 0) || (ch == 3);
    endfunction : has_clr_hi

    function automatic logic has_phase(input int ch);
        has_phase = (ch == 1) || (ch == 2) || (ch == 4) || (ch == 5);
    endfunction : has_phase

    function automatic tccs_pkg::tccs_src_t src_of(input int ch, input logic [2:0] psc);
        tccs_pkg::tccs_src_t s;
        s = tccs_pkg::SRC_D1;
        case (psc)
            3'h0: s = tccs_pkg::SRC_D1;
            3'h1: s = tccs_pkg::SRC_D4;
            3'h2: s = tccs_pkg::SRC_D16;
            3'h3: s = tccs_pkg::SRC_D64;
            3'h4: s = tccs_pkg::SRC_PIN_A;
            3'h5: begin
                case (ch)
                    3: s = tccs_pkg::SRC_D1024;
                    4, 5: s = tccs_pkg::SRC_PIN_C;
                    default: s = tccs_pkg::SRC_PIN_B;
                endcase
            end
            3'h6: begin
                case (ch)
                    1, 3, 5: s = tccs_pkg::SRC_D256;
                    4: s = tccs_pkg::SRC_D1024;
                    default: s = tccs_pkg::SRC_PIN_C;
                endcase
            end
            default: begin
                case (ch)
                    1: s = tccs_pkg::SRC_OVF2;
                    2: s = tccs_pkg::SRC_D1024;
                    3: s = tccs_pkg::SRC_D4096;
                    4: s = tccs_pkg::SRC_OVF5;
                    default: s = tccs_pkg::SRC_PIN_D;
                endcase
            end
        endcase
        return s;
    endfunction : src_of

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    tccs_pkg::tccs_ctrl_t ctrl [6];
    logic [5:0] sync_select_register;
    logic [5:0] phase_mode;
    logic [11:0] div_cnt;
    logic [11:0] div_prev;
    logic [3:0] pin_prev;
    logic [3:0] pins_now;
    logic [12:0] src_rise;
    logic [12:0] src_fall;
    logic [5:0] next_enable;
    logic [5:0] next_down;
    logic [5:0] own_clear;
    logic [5:0] next_clear;
    logic [5:0] next_wrap;
    logic [5:0] cnt_wr;
    logic sync_clear_any;

    assign pins_now = {ext_clock_pin_d, ext_clock_pin_c, ext_clock_pin_b, ext_clock_pin_a};
    // pins arrive synchronous, so one stage for edge detection suffices

    // ------------------------------------------------------------
    // prescaler and edge sampling
    // ------------------------------------------------------------
    // one shared divider keeps all internal sources phase aligned
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            div_cnt <= tccs_pkg::DIV_RST;
            div_prev <= tccs_pkg::DIV_RST;
        end else begin
            div_cnt <= div_cnt + 12'h001;
            div_prev <= div_cnt;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pin_prev <= 4'h0;
        end else begin
            pin_prev <= pins_now;
        end
    end

    // rise/fall strobes indexed by source code
    always_comb begin
        src_rise = '0;
        src_fall = '0;
        src_rise[tccs_pkg::SRC_D1] = 1'b1;
        src_rise[tccs_pkg::SRC_D4] = div_cnt[tccs_pkg::TAP_D4] & ~div_prev[tccs_pkg::TAP_D4];
        src_fall[tccs_pkg::SRC_D4] = ~div_cnt[tccs_pkg::TAP_D4] & div_prev[tccs_pkg::TAP_D4];
        src_rise[tccs_pkg::SRC_D16] = div_cnt[tccs_pkg::TAP_D16] & ~div_prev[tccs_pkg::TAP_D16];
        src_fall[tccs_pkg::SRC_D16] = ~div_cnt[tccs_pkg::TAP_D16] & div_prev[tccs_pkg::TAP_D16];
        src_rise[tccs_pkg::SRC_D64] = div_cnt[tccs_pkg::TAP_D64] & ~div_prev[tccs_pkg::TAP_D64];
        src_fall[tccs_pkg::SRC_D64] = ~div_cnt[tccs_pkg::TAP_D64] & div_prev[tccs_pkg::TAP_D64];
        src_rise[tccs_pkg::SRC_D256] = div_cnt[tccs_pkg::TAP_D256] & ~div_prev[tccs_pkg::TAP_D256];
        src_fall[tccs_pkg::SRC_D256] = ~div_cnt[tccs_pkg::TAP_D256] & div_prev[tccs_pkg::TAP_D256];
        src_rise[tccs_pkg::SRC_D1024] =
            div_cnt[tccs_pkg::TAP_D1024] & ~div_prev[tccs_pkg::TAP_D1024];
        src_fall[tccs_pkg::SRC_D1024] =
            ~div_cnt[tccs_pkg::TAP_D1024] & div_prev[tccs_pkg::TAP_D1024];
        src_rise[tccs_pkg::SRC_D4096] =
            div_cnt[tccs_pkg::TAP_D4096] & ~div_prev[tccs_pkg::TAP_D4096];
        src_fall[tccs_pkg::SRC_D4096] =
            ~div_cnt[tccs_pkg::TAP_D4096] & div_prev[tccs_pkg::TAP_D4096];
        for (int p = 0; p < 4; p++) begin
            src_rise[int'(tccs_pkg::SRC_PIN_A) + p] = pins_now[p] & ~pin_prev[p];
            src_fall[int'(tccs_pkg::SRC_PIN_A) + p] = ~pins_now[p] & pin_prev[p];
        end
        // registered wrap pulses: the cascade lags one cycle but has no
        // combinational path running through two counters
        src_rise[tccs_pkg::SRC_OVF2] = wrap_pulse[2];
        src_rise[tccs_pkg::SRC_OVF5] = wrap_pulse[5];
    end

    // ------------------------------------------------------------
    // count enable and direction per channel
    // ------------------------------------------------------------
    always_comb begin
        tccs_pkg::tccs_src_t s;
        logic [1:0] edg;
        s = tccs_pkg::SRC_D1;
        edg = 2'h0;
        next_enable = '0;
        next_down = '0;
        for (int ch = 0; ch < tccs_pkg::NUM_CH; ch++) begin
            s = src_of(ch, {ctrl[ch].prescale_sel_bit2, ctrl[ch].prescale_sel_bit1,
                            ctrl[ch].prescale_sel_bit0});
            edg = {ctrl[ch].edge_select_hi, ctrl[ch].edge_select_lo};
            if (has_phase(ch) && phase_mode[ch]) begin
                // phase decoder pulses replace the prescale choice
                next_enable[ch] = events.phase_step[ch];
                next_down[ch] = events.phase_down[ch];
            end else if (s == tccs_pkg::SRC_D1 || s == tccs_pkg::SRC_OVF2 ||
                         s == tccs_pkg::SRC_OVF5) begin
                next_enable[ch] = src_rise[s];
            end else if (edg[1]) begin
                next_enable[ch] = src_rise[s] | src_fall[s];
            end else if (edg[0]) begin
                next_enable[ch] = src_fall[s];
            end else begin
                next_enable[ch] = src_rise[s];
            end
        end
    end

    // ------------------------------------------------------------
    // clear selection
    // ------------------------------------------------------------
    // top clear bit set on channels 0/3 points at C/D, which this block lacks
    always_comb begin
        logic [1:0] sel;
        sel = 2'h0;
        own_clear = '0;
        for (int ch = 0; ch < tccs_pkg::NUM_CH; ch++) begin
            sel = {ctrl[ch].clear_source_sel_hi, ctrl[ch].clear_source_sel_lo};
            if (!ctrl[ch].clear_source_sel_hi2) begin
                own_clear[ch] = ((sel == tccs_pkg::CLR_GRA) && events.match_a[ch])
                              | ((sel == tccs_pkg::CLR_GRB) && events.match_b[ch]);
            end
        end
    end

    assign sync_clear_any = |(own_clear & sync_select_register);

    always_comb begin
        next_clear = '0;
        for (int ch = 0; ch < tccs_pkg::NUM_CH; ch++) begin
            if ({ctrl[ch].clear_source_sel_hi, ctrl[ch].clear_source_sel_lo}
                == tccs_pkg::CLR_SYNC) begin
                next_clear[ch] = sync_select_register[ch] & sync_clear_any;
            end else begin
                next_clear[ch] = own_clear[ch];
            end
        end
    end

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            for (int ch = 0; ch < tccs_pkg::NUM_CH; ch++) begin
                ctrl[ch] <= tccs_pkg::CTRL_RST;
            end
        end else if (bus_req.wr_stb) begin
            for (int ch = 0; ch < tccs_pkg::NUM_CH; ch++) begin
                if (bus_req.addr == tccs_pkg::ADDR_CTRL0 + 5'(ch)) begin
                    ctrl[ch] <= bus_req.wdata[7:0];
                    if (!has_clr_hi(ch)) begin
                        ctrl[ch].clear_source_sel_hi2 <= 1'b0;
                    end
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sync_select_register <= tccs_pkg::SYNC_RST;
            phase_mode <= tccs_pkg::PHASE_RST;
        end else if (bus_req.wr_stb) begin
            if (bus_req.addr == tccs_pkg::ADDR_SYNC) begin
                sync_select_register <= bus_req.wdata[5:0];
            end
            if (bus_req.addr == tccs_pkg::ADDR_PHASE) begin
                // channels 0 and 3 have no phase counting
                phase_mode <= bus_req.wdata[5:0] & 6'h36;
            end
        end
    end

    always_comb begin
        cnt_wr = '0;
        for (int ch = 0; ch < tccs_pkg::NUM_CH; ch++) begin
            cnt_wr[ch] = bus_req.wr_stb && (bus_req.addr == tccs_pkg::ADDR_CNT0 + 5'(ch));
        end
    end

    // ------------------------------------------------------------
    // counters: software write beats clear, clear beats counting
    // ------------------------------------------------------------
    always_comb begin
        // wrap only on a counted step; a write or clear on that edge wins
        next_wrap = '0;
        for (int ch = 0; ch < tccs_pkg::NUM_CH; ch++) begin
            if (!cnt_wr[ch] && !next_clear[ch] && next_enable[ch]) begin
                next_wrap[ch] = next_down[ch]
                    ? (channel_count_value[ch] == tccs_pkg::CNT_RST)
                    : (channel_count_value[ch] == tccs_pkg::CNT_MAX);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            for (int ch = 0; ch < tccs_pkg::NUM_CH; ch++) begin
                channel_count_value[ch] <= tccs_pkg::CNT_RST;
            end
        end else begin
            for (int ch = 0; ch < tccs_pkg::NUM_CH; ch++) begin
                if (cnt_wr[ch]) begin
                    channel_count_value[ch] <= bus_req.wdata;
                end else if (next_clear[ch]) begin
                    channel_count_value[ch] <= tccs_pkg::CNT_RST;
                end else if (next_enable[ch]) begin
                    channel_count_value[ch] <= next_down[ch]
                        ? channel_count_value[ch] - 16'h0001
                        : channel_count_value[ch] + 16'h0001;
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wrap_pulse <= '0;
            clear_pulse <= '0;
            count_enable <= '0;
        end else begin
            wrap_pulse <= next_wrap;
            clear_pulse <= next_clear & ~cnt_wr;
            count_enable <= next_enable;
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rd_data <= 16'h0000;
        end else if (bus_req.rd_stb) begin
            rd_data <= 16'h0000;
            for (int ch = 0; ch < tccs_pkg::NUM_CH; ch++) begin
                if (bus_req.addr == tccs_pkg::ADDR_CTRL0 + 5'(ch)) begin
                    rd_data <= {8'h00, ctrl[ch]};
                end
                if (bus_req.addr == tccs_pkg::ADDR_CNT0 + 5'(ch)) begin
                    rd_data <= channel_count_value[ch];
                end
            end
            if (bus_req.addr == tccs_pkg::ADDR_SYNC) begin
                rd_data <= {10'h000, sync_select_register};
            end
            if (bus_req.addr == tccs_pkg::ADDR_PHASE) begin
                rd_data <= {10'h000, phase_mode};
            end
        end else begin
            rd_data <= 16'h0000;
        end
    end

endmodule : tccs_top

// ==== sim/tccs_pin_model.sv ====
// partner: external count clock pins driven in short bursts
`timescale 1ns/1ps
module tccs_pin_model (
    input wire logic ref_clk, // system clock
    input wire logic sys_rst, // synchronous reset
    input wire logic go, // start one burst on every pin
    output logic [3:0] pins // pins d..a, low while idle
);
    // ----------------------------------------
    // burst engine: pin i gives i+1 pulses
    // ----------------------------------------
    logic [3:0][2:0] left; // pulses still owed per pin
    logic [1:0] ph; // two cycles high, two low
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            left <= '0;
            ph <= 2'h0;
        end else if (go) begin
            for (int i = 0; i < 4; i++)
                left[i] <= 3'(i + 1);
            ph <= 2'h0;
        end else begin
            ph <= ph + 2'h1;
            for (int i = 0; i < 4; i++)
                if (ph == 2'h3 && left[i] != 3'h0)
                    left[i] <= left[i] - 3'h1;
        end
    end
    // distinct counts per pin expose a wrong pin choice
    always_comb
        for (int i = 0; i < 4; i++)
            pins[i] = (left[i] != 3'h0) && !ph[1];
endmodule : tccs_pin_model

// ==== sim/tccs_checker.sv ====
// checker: port-level assertions for the timer clock and clear select block
`timescale 1ns/1ps
module tccs_checker (
    input wire logic ref_clk, // system clock
    input wire logic sys_rst, // synchronous reset
    input wire tccs_pkg::tccs_bus_req_t bus_req, // register port request
    input wire logic [15:0] rd_data, // read data
    input wire tccs_pkg::tccs_event_t events, // compare and phase pulses
    input wire logic [5:0] wrap_pulse, // wrap pulses
    input wire logic [5:0] clear_pulse, // clear pulses
    input wire logic [5:0] count_enable // count enables
);
    // ----------------------------------------
    // shadow of the written settings
    // ----------------------------------------
    logic [5:0][7:0] ctl;
    logic [5:0] sync_sel;
    logic [5:0] phase_on;
    logic cnt_wr;
    assign cnt_wr = bus_req.wr_stb && bus_req.addr[4:3] == 2'b01;
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ctl <= '0;
            sync_sel <= '0;
            phase_on <= '0;
        end else if (bus_req.wr_stb) begin
            if (bus_req.addr < 5'h06)
                ctl[bus_req.addr[2:0]] <= bus_req.wdata[7:0];
            if (bus_req.addr == tccs_pkg::ADDR_SYNC)
                sync_sel <= bus_req.wdata[5:0];
            if (bus_req.addr == tccs_pkg::ADDR_PHASE)
                phase_on <= bus_req.wdata[5:0];
        end
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // three steady cycles keep reset and write edges out of the window
    sequence d1_steady;
        (ctl[0][2:0] == 3'h0 && ctl[0][6:5] == 2'h0 && !cnt_wr) [*3];
    endsequence
    sequence d4_steady;
        (ctl[0] == 8'h01) [*3];
    endsequence
    rd_idle_a: assert property (!bus_req.rd_stb |=> rd_data == 16'h0000)
        else $error("read data not zero outside read slot");
    unmapped_rd_a: assert property (bus_req.rd_stb && bus_req.addr == 5'h1f
        |=> rd_data == 16'h0000) else $error("unmapped read not zero");
    rsvd_bit_a: assert property (bus_req.rd_stb && bus_req.addr inside
        {5'h01, 5'h02, 5'h04, 5'h05} |=> !rd_data[7])
        else $error("reserved clear bit read as one");
    free_run_a: assert property (ctl[1][6:5] == tccs_pkg::CLR_NONE |=> !clear_pulse[1])
        else $error("free running channel was cleared");
    gra_clear_a: assert property (ctl[1][6:5] == tccs_pkg::CLR_GRA && !cnt_wr
        |=> clear_pulse[1] == $past(events.match_a[1])) else $error("clear on A wrong");
    grb_clear_a: assert property (ctl[5][6:5] == tccs_pkg::CLR_GRB && !cnt_wr
        |=> clear_pulse[5] == $past(events.match_b[5])) else $error("clear on B wrong");
    sync_clear_a: assert property (ctl[2][6:5] == tccs_pkg::CLR_SYNC && sync_sel[2]
        && sync_sel[1] && ctl[1][6:5] == tccs_pkg::CLR_GRA && events.match_a[1] && !cnt_wr
        |=> clear_pulse[2]) else $error("sync member not cleared");
    sync_gate_a: assert property (ctl[4][6:5] == tccs_pkg::CLR_SYNC && !sync_sel[4]
        |=> !clear_pulse[4]) else $error("non member cleared by sync");
    div1_count_a: assert property (d1_steady |-> count_enable[0])
        else $error("undivided clock missed a count");
    div4_gap_a: assert property (d4_steady
        |-> !(count_enable[0] && $past(count_enable[0])))
        else $error("divided clock counted twice in a row");
    cascade_cnt_a: assert property ((ctl[1][2:0] == 3'h7 && ctl[1][6:5] == 2'h0
        && !phase_on[1] && !cnt_wr) [*2] |-> count_enable[1] == $past(wrap_pulse[2]))
        else $error("cascade count does not follow wrap");
    phase_only_a: assert property (phase_on[1] && !events.phase_step[1] && !cnt_wr
        |=> !count_enable[1]) else $error("phase channel counted prescale");
endmodule : tccs_checker

bind tccs_top tccs_checker u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .bus_req(bus_req),
    .rd_data(rd_data), .events(events), .wrap_pulse(wrap_pulse),
    .clear_pulse(clear_pulse), .count_enable(count_enable));

// ==== sim/testbench.sv ====
// testbench: register tasks and clock and clear selection scenarios
`timescale 1ns/1ps
module testbench;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    tccs_pkg::tccs_bus_req_t bus_req = '0;
    tccs_pkg::tccs_event_t events = '0;
    logic go = 1'b0;
    logic [3:0] pins;
    logic [15:0] rd_data;
    logic [5:0][15:0] cnt_val;
    logic [5:0] wrap_pulse;
    logic [5:0] clear_pulse;
    logic [5:0] count_enable;
    logic [15:0] d0;
    logic [15:0] d1;
    int error_cnt = 0;
    int checks_done = 0;

    always #2.5 ref_clk = ~ref_clk;

    tccs_top uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .bus_req(bus_req), .rd_data(rd_data),
        .ext_clock_pin_a(pins[0]), .ext_clock_pin_b(pins[1]), .ext_clock_pin_c(pins[2]),
        .ext_clock_pin_d(pins[3]), .events(events), .channel_count_value(cnt_val),
        .wrap_pulse(wrap_pulse), .clear_pulse(clear_pulse), .count_enable(count_enable));
    tccs_pin_model u_pins (.ref_clk(ref_clk), .sys_rst(sys_rst), .go(go), .pins(pins));

    // ----------------------------------------
    // bus and compare tasks
    // ----------------------------------------
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        bus_req <= '{wr_stb: 1'b1, rd_stb: 1'b0, addr: a, wdata: d};
        @(posedge ref_clk);
        bus_req <= '0;
    endtask : wr
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        bus_req <= '{wr_stb: 1'b0, rd_stb: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge ref_clk);
        bus_req <= '0;
        #1;
        d = rd_data;
    endtask : rd
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic rchk(input logic [4:0] a, input logic [15:0] exp);
        rd(a, d0);
        chk(d0, exp);
    endtask : rchk
    // count delta over a window; div 0 means a pin burst window
    task automatic run_case(input int ch, input logic [7:0] c, input int div,
        input logic [15:0] e);
        wr(tccs_pkg::ADDR_CTRL0 + 5'(ch), {8'h00, c});
        rd(tccs_pkg::ADDR_CNT0 + 5'(ch), d0);
        go <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
        repeat (div == 0 ? 24 : 4 * div - 3) @(posedge ref_clk);
        rd(tccs_pkg::ADDR_CNT0 + 5'(ch), d1);
        chk(d1 - d0, e);
    endtask : run_case
    task automatic clr(input logic [5:0] ma, input logic [5:0] mb, input logic [5:0] e);
        @(posedge ref_clk);
        events <= '{match_a: ma, match_b: mb, phase_step: 6'h00, phase_down: 6'h00};
        @(posedge ref_clk);
        events <= '0;
        // the pulse stands only in the cycle after the match edge
        #1;
        chk({10'h000, clear_pulse}, {10'h000, e});
    endtask : clr
    task automatic conclude;
        $display("checks=%0d errors=%0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : conclude

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rchk(tccs_pkg::ADDR_CTRL0, 16'h0000);
        rchk(tccs_pkg::ADDR_SYNC, 16'h0000);
        wr(5'h1f, 16'hffff);
        rchk(5'h1f, 16'h0000);
        wr(5'h01, 16'h00ff);
        rchk(5'h01, 16'h007f);
        wr(5'h05, 16'h0080);
        rchk(5'h05, 16'h0000);
        wr(5'h00, 16'h00ff);
        rchk(5'h00, 16'h00ff);
        run_case(0, 8'h00, 1, 4);
        run_case(0, 8'h01, 4, 4);
        run_case(0, 8'h02, 16, 4);
        run_case(0, 8'h03, 64, 4);
        run_case(3, 8'h01, 4, 4);
        run_case(5, 8'h02, 16, 4);
        run_case(0, 8'h04, 0, 1);
        run_case(0, 8'h05, 0, 2);
        run_case(0, 8'h06, 0, 3);
        run_case(0, 8'h07, 0, 4);
        run_case(1, 8'h04, 0, 1);
        run_case(1, 8'h05, 0, 2);
        run_case(1, 8'h06, 256, 4);
        run_case(2, 8'h04, 0, 1);
        run_case(2, 8'h05, 0, 2);
        run_case(2, 8'h06, 0, 3);
        run_case(2, 8'h07, 1024, 4);
        run_case(3, 8'h04, 0, 1);
        run_case(3, 8'h05, 1024, 4);
        run_case(3, 8'h06, 256, 4);
        run_case(3, 8'h07, 4096, 4);
        run_case(4, 8'h04, 0, 1);
        run_case(4, 8'h05, 0, 3);
        run_case(4, 8'h06, 1024, 4);
        run_case(0, 8'h11, 4, 8);
        run_case(0, 8'h0a, 16, 4);
        run_case(0, 8'h14, 0, 2);
        run_case(0, 8'h0c, 0, 1);
        run_case(0, 8'h10, 1, 4);
        wr(tccs_pkg::ADDR_PHASE, 16'h003f);
        rchk(tccs_pkg::ADDR_PHASE, 16'h0036);
        run_case(1, 8'h00, 1, 0);
        run_case(2, 8'h00, 1, 0);
        run_case(4, 8'h00, 1, 0);
        wr(tccs_pkg::ADDR_CNT0 + 5'h1, 16'h0000);
        wr(tccs_pkg::ADDR_CNT0 + 5'h2, 16'h0000);
        wr(tccs_pkg::ADDR_CNT0 + 5'h4, 16'h0000);
        events <= '{match_a: 6'h00, match_b: 6'h00, phase_step: 6'h16, phase_down: 6'h04};
        repeat (3) @(posedge ref_clk);
        events <= '0;
        rchk(tccs_pkg::ADDR_CNT0 + 5'h1, 16'h0003);
        rchk(tccs_pkg::ADDR_CNT0 + 5'h2, 16'hfffd);
        rchk(tccs_pkg::ADDR_CNT0 + 5'h4, 16'h0003);
        wr(tccs_pkg::ADDR_PHASE, 16'h0000);
        // write the far counter first so no wrap slips in before the zeroing
        for (int i = 1; i < 5; i += 3) begin
            wr(tccs_pkg::ADDR_CTRL0 + 5'(i + 1), 16'h0000);
            wr(tccs_pkg::ADDR_CNT0 + 5'(i + 1), 16'hfff0);
            wr(tccs_pkg::ADDR_CTRL0 + 5'(i), 16'h0007);
            wr(tccs_pkg::ADDR_CNT0 + 5'(i), 16'h0000);
            repeat (40) @(posedge ref_clk);
            rchk(tccs_pkg::ADDR_CNT0 + 5'(i), 16'h0001);
            chk(cnt_val[i], 16'h0001);
        end
        wr(5'h00, 16'h0000);
        wr(5'h01, 16'h0020);
        wr(5'h02, 16'h0060);
        wr(5'h04, 16'h0060);
        wr(5'h05, 16'h0040);
        wr(tccs_pkg::ADDR_SYNC, 16'h0006);
        clr(6'h01, 6'h01, 6'h00);
        clr(6'h02, 6'h00, 6'h06);
        chk(cnt_val[2], 16'h0000);
        clr(6'h00, 6'h02, 6'h00);
        clr(6'h00, 6'h20, 6'h20);
        clr(6'h20, 6'h00, 6'h00);
        wr(tccs_pkg::ADDR_SYNC, 16'h0016);
        clr(6'h02, 6'h00, 6'h16);
        wr(tccs_pkg::ADDR_SYNC, 16'h0012);
        clr(6'h02, 6'h00, 6'h12);
        conclude();
    end
endmodule : testbench
